// *** ecd_pkg.sv ***
// Shared constants and types for the external control input decoder
package ecd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Pin vector layout after synchronisation
	localparam int IN_W = 12;
	localparam int IDX_MUX = 0;
	localparam int IDX_HALT = 1;
	localparam int IDX_FIRE = 2;
	localparam int IDX_BCDLOW = 3;
	localparam int IDX_SPA = 4;
	localparam int IDX_SPB = 5;
	localparam int IDX_CODE = 6;
	localparam int CODE_W = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on APB
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam int CTRL_W = 4;
	localparam int CTRL_SCAN_LSB = 0;
	localparam int CTRL_BCD_BIT = 2;
	localparam int CTRL_EXTTRIG_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h8;
	localparam logic [1:0] SCAN_OFF = 2'h0;
	localparam logic [1:0] SCAN_AUTO = 2'h1;
	localparam logic [1:0] SCAN_STEP = 2'h2;
	localparam int ST_SPA_BIT = 0;
	localparam int ST_SPB_BIT = 1;
	localparam int ST_PEND_BIT = 2;
	localparam int ST_STOP_BIT = 3;
	localparam int ST_KEY_BIT = 4;
	localparam int ST_ERR_BIT = 5;
	localparam int ST_CODE_LSB = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Valid code ranges and timing
	localparam logic [5:0] CODE_NONE = 6'h00;
	localparam logic [5:0] PANEL_MAX = 6'h1E;
	localparam logic [5:0] CHANNEL_MAX = 6'h20;
	localparam int STABLE_MS = 10;
	localparam int CLK_KHZ = 50000;
	localparam int STABLE_CYC_DEF = STABLE_MS * CLK_KHZ;
	localparam int CNT_W = 20;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOAD = 3'b010,
		ST_MEAS = 3'b100
	} ecd_state_type;

	typedef struct packed {
		logic [IN_W-1:0] stage1;
		logic [IN_W-1:0] stage2;
		logic [IN_W-1:0] prev;
	} ecd_sync_type;

	typedef struct packed {
		ecd_state_type state;
		logic [CTRL_W-1:0] ctrl;
		logic [CODE_W-1:0] lastCode;
		logic [CODE_W-1:0] prevCode;
		logic [CNT_W-1:0] stableCnt;
		logic haltPending;
		logic initialNext;
		logic scanStopped;
		logic errorOut;
		logic keyLock;
		logic panelStrobe;
		logic chanStrobe;
		logic [CODE_W-1:0] loadNumber;
		logic measureStart;
		logic fromInitial;
		logic upperSel;
		logic lowerSel;
		logic spareA;
		logic spareB;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ecd_regs_type;

	localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
	localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
endpackage

// *** ecd_sync_edge.sv ***
// Two-stage synchroniser with rising-edge detect for the control pins
module ecd_sync_edge (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic [ecd_pkg::IN_W-1:0] pins, // Raw control inputs
	output logic [ecd_pkg::IN_W-1:0] level, // Synchronised levels
	output logic [ecd_pkg::IN_W-1:0] rise // Off-to-on pulses
);
	ecd_pkg::ecd_sync_type st, next_st;

	////////////////////////////////////////////////////////////////////////////////
	// Stage1 only feeds stage2, metastability stays contained
	always_comb begin
		next_st.stage1 = pins;
		next_st.stage2 = st.stage1;
		next_st.prev = st.stage2;
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Edge taken from settled stages only
	assign level = st.stage2;
	assign rise = st.stage2 & ~st.prev;
endmodule

// *** ecd_decoder.sv ***
// External control input decoder with APB control and status registers
// How it works
// - Load code means panel number or channel depending on selector input.
// - Scan halt input acts only in auto or step scan.
// - Auto scan: halt edge pends; stop after measurement, restart from first channel.
// - Step scan: halt edge while awaiting trigger makes next trigger use first channel.
// - Coded-decimal output: digit-half input off gives upper, on gives lower digits.
// - Trigger takes code, loads panel or channel, then measures.
// - First load bit is least significant, sixth most significant.
// - Trigger with unchanged code measures once, no load or switch.
// - Valid code stable for 10 ms loads without a trigger.
// - Load code stays honoured under remote control.
// - Keys locked while code is a valid panel or channel.
// - Auto or step scan: load code never changes the channel.
// - Channel switch refused with error when front leads are attached.
// - Both spare inputs readable as status.
// - Error output follows non-range faults, updated with measurement done.
// - Trigger, halt and settled-code loads ignored while measurement screen not shown.
module ecd_decoder #(
	parameter int STABLE_CYCLES = ecd_pkg::STABLE_CYC_DEF // Load code settle time in cycles
) (
	input wire logic clk, // System clock, 50 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [ecd_pkg::ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic channelSelectorEnable, // Code selects channel when high
	input wire logic scanHaltRequest, // Scan stop request
	input wire logic [5:0] loadCodeBit, // Load code, bit 0 is lsb
	input wire logic measureTrigger, // Measurement trigger
	input wire logic bcdLowSelect, // Lower digit half select
	input wire logic spareInputA, // General input A
	input wire logic spareInputB, // General input B
	input wire logic screenReady, // Measurement screen shown, no error
	input wire logic frontLeadsAttached, // Leads on front terminals
	input wire logic measureDone, // Measurement finished pulse
	input wire logic measureFault, // Non-range fault of that measurement
	output logic panelLoadStrobe, // Load panel pulse
	output logic channelSwitchStrobe, // Switch channel pulse
	output logic [5:0] loadNumber, // Panel or channel number
	output logic measureStart, // Start one measurement pulse
	output logic fromInitialChannel, // Measure from first channel
	output logic keyLockout, // Front keys disabled
	output logic bcdUpperSelect, // Present upper digits
	output logic bcdLowerSelect, // Present lower digits and range
	output logic errorOut, // Error output
	output logic scanStopped // Scan halted
);
	ecd_pkg::ecd_regs_type st, next_st;
	logic [ecd_pkg::IN_W-1:0] pinVec, lvl, rise;
	logic [5:0] code;
	logic live, scanOn, codeOk, sameCode, autoFire, fireRise, haltRise;
	logic apbWr, apbRd, hit;

	////////////////////////////////////////////////////////////////////////////////
	// Valid number for the current meaning of the code
	function automatic logic codeValid(input logic [5:0] c, input logic channel_selector_enable);
		if (c == ecd_pkg::CODE_NONE) begin
			codeValid = 1'b0;
		end else if (channel_selector_enable) begin
			codeValid = (c <= ecd_pkg::CHANNEL_MAX);
		end else begin
			codeValid = (c <= ecd_pkg::PANEL_MAX);
		end
	endfunction

	// Pin gathering; bit order kept as wired
	assign pinVec = {loadCodeBit, spareInputB, spareInputA, bcdLowSelect, measureTrigger,
		scanHaltRequest, channelSelectorEnable};

	ecd_sync_edge u_sync (
		.clk(clk),
		.rst(rst),
		.pins(pinVec),
		.level(lvl),
		.rise(rise)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decoded conditions
	assign code = lvl[ecd_pkg::IDX_CODE +: ecd_pkg::CODE_W];
	assign live = screenReady;
	assign scanOn = (st.ctrl[ecd_pkg::CTRL_SCAN_LSB +: 2] == ecd_pkg::SCAN_AUTO) ||
		(st.ctrl[ecd_pkg::CTRL_SCAN_LSB +: 2] == ecd_pkg::SCAN_STEP);
	assign codeOk = codeValid(code, lvl[ecd_pkg::IDX_MUX]);
	assign sameCode = (code == st.lastCode);
	assign fireRise = live && rise[ecd_pkg::IDX_FIRE];
	assign haltRise = live && scanOn && rise[ecd_pkg::IDX_HALT];
	// Fires once when the code has stood still long enough
	assign autoFire = live && codeOk && !sameCode && (code == st.prevCode) &&
		(st.stableCnt == ecd_pkg::CNT_W'(STABLE_CYCLES - 1));
	assign apbWr = psel && penable && pwrite && !st.pready;
	assign apbRd = psel && penable && !pwrite && !st.pready;
	assign hit = (paddr == ecd_pkg::ADDR_CTRL) || (paddr == ecd_pkg::ADDR_STATUS);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		next_st = st;
		next_st.panelStrobe = 1'b0;
		next_st.chanStrobe = 1'b0;
		next_st.measureStart = 1'b0;
		// Stability timer restarts on every code change
		if (code != st.prevCode) begin
			next_st.prevCode = code;
			next_st.stableCnt = ecd_pkg::CNT_ZERO;
		end else if (st.stableCnt != ecd_pkg::CNT_W'(STABLE_CYCLES)) begin
			next_st.stableCnt = st.stableCnt + ecd_pkg::CNT_ONE;
		end
		case (st.state)
			ecd_pkg::ST_IDLE: begin
				if (fireRise && (sameCode || !codeOk)) begin
					// Unchanged code: plain measurement, no load
					if (st.ctrl[ecd_pkg::CTRL_EXTTRIG_BIT]) begin
						next_st.state = ecd_pkg::ST_LOAD;
					end
				end else if (fireRise || autoFire) begin
					if (lvl[ecd_pkg::IDX_MUX] && scanOn) begin
						// Scan owns the channel; code is not applied
						next_st.state = fireRise ? ecd_pkg::ST_LOAD : ecd_pkg::ST_IDLE;
					end else if (lvl[ecd_pkg::IDX_MUX] && frontLeadsAttached) begin
						next_st.errorOut = 1'b1;
					end else begin
						next_st.panelStrobe = !lvl[ecd_pkg::IDX_MUX];
						next_st.chanStrobe = lvl[ecd_pkg::IDX_MUX];
						next_st.loadNumber = code;
						next_st.lastCode = code;
						next_st.state = fireRise ? ecd_pkg::ST_LOAD : ecd_pkg::ST_IDLE;
					end
				end
			end
			ecd_pkg::ST_LOAD: begin
				// Measure one cycle after the load pulse
				next_st.measureStart = 1'b1;
				next_st.fromInitial = st.initialNext;
				next_st.initialNext = 1'b0;
				next_st.scanStopped = 1'b0;
				next_st.state = ecd_pkg::ST_MEAS;
			end
			ecd_pkg::ST_MEAS: begin
				if (measureDone) begin
					next_st.errorOut = measureFault;
					if (st.haltPending) begin
						next_st.haltPending = 1'b0;
						next_st.scanStopped = 1'b1;
						next_st.initialNext = 1'b1;
					end
					next_st.state = ecd_pkg::ST_IDLE;
				end
			end
			default: begin
				next_st.state = ecd_pkg::ST_IDLE;
			end
		endcase
		// Halt edges last so a new request beats the clear
		if (haltRise && st.ctrl[ecd_pkg::CTRL_SCAN_LSB +: 2] == ecd_pkg::SCAN_AUTO) begin
			next_st.haltPending = 1'b1;
		end
		if (haltRise && st.ctrl[ecd_pkg::CTRL_SCAN_LSB +: 2] == ecd_pkg::SCAN_STEP &&
			st.state == ecd_pkg::ST_IDLE) begin
			next_st.initialNext = 1'b1;
		end
		// Level outputs; remote mode is no gate here
		next_st.keyLock = codeOk;
		next_st.upperSel = st.ctrl[ecd_pkg::CTRL_BCD_BIT] && !lvl[ecd_pkg::IDX_BCDLOW];
		next_st.lowerSel = st.ctrl[ecd_pkg::CTRL_BCD_BIT] && lvl[ecd_pkg::IDX_BCDLOW];
		next_st.spareA = lvl[ecd_pkg::IDX_SPA];
		next_st.spareB = lvl[ecd_pkg::IDX_SPB];
		// APB: ready one cycle into the access phase
		next_st.pready = psel && penable && !st.pready;
		next_st.pslverr = psel && penable && !st.pready && !hit;
		next_st.prdata = '0;
		if (apbWr && paddr == ecd_pkg::ADDR_CTRL) begin
			next_st.ctrl = pwdata[ecd_pkg::CTRL_W-1:0];
		end
		if (apbRd && paddr == ecd_pkg::ADDR_CTRL) begin
			next_st.prdata[ecd_pkg::CTRL_W-1:0] = st.ctrl;
		end
		if (apbRd && paddr == ecd_pkg::ADDR_STATUS) begin
			next_st.prdata[ecd_pkg::ST_SPA_BIT] = st.spareA;
			next_st.prdata[ecd_pkg::ST_SPB_BIT] = st.spareB;
			next_st.prdata[ecd_pkg::ST_PEND_BIT] = st.haltPending;
			next_st.prdata[ecd_pkg::ST_STOP_BIT] = st.scanStopped;
			next_st.prdata[ecd_pkg::ST_KEY_BIT] = st.keyLock;
			next_st.prdata[ecd_pkg::ST_ERR_BIT] = st.errorOut;
			next_st.prdata[ecd_pkg::ST_CODE_LSB +: ecd_pkg::CODE_W] = st.lastCode;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.state <= ecd_pkg::ST_IDLE;
			st.ctrl <= ecd_pkg::CTRL_RESET;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign panelLoadStrobe = st.panelStrobe;
	assign channelSwitchStrobe = st.chanStrobe;
	assign loadNumber = st.loadNumber;
	assign measureStart = st.measureStart;
	assign fromInitialChannel = st.fromInitial;
	assign keyLockout = st.keyLock;
	assign bcdUpperSelect = st.upperSel;
	assign bcdLowerSelect = st.lowerSel;
	assign errorOut = st.errorOut;
	assign scanStopped = st.scanStopped;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_MUX_MEANING: assert property (channelSwitchStrobe |->
		$past(lvl[ecd_pkg::IDX_MUX]) && !panelLoadStrobe)
		else $error("channel switch without selector enabled");
	AST_HALT_GATED: assert property ($rose(st.haltPending) |-> $past(scanOn))
		else $error("halt pended outside scan");
	AST_HALT_STOP: assert property (st.state == ecd_pkg::ST_MEAS && measureDone && st.haltPending
		|=> scanStopped && st.initialNext ##[1:1000] !st.initialNext)
		else $error("pending halt not applied");
	AST_STEP_INIT: assert property (haltRise && st.state == ecd_pkg::ST_IDLE &&
		st.ctrl[ecd_pkg::CTRL_SCAN_LSB +: 2] == ecd_pkg::SCAN_STEP |=> st.initialNext)
		else $error("step halt not recorded");
	AST_DIGIT_HALF: assert property (st.ctrl[ecd_pkg::CTRL_BCD_BIT] && $stable(st.ctrl) &&
		lvl[ecd_pkg::IDX_BCDLOW] |=> bcdLowerSelect && !bcdUpperSelect)
		else $error("wrong digit half");
	AST_LOAD_MEASURE: assert property ((panelLoadStrobe || channelSwitchStrobe) &&
		st.state == ecd_pkg::ST_LOAD |=> measureStart)
		else $error("trigger load not followed by measurement");
	AST_SAME_CODE: assert property ((panelLoadStrobe || channelSwitchStrobe) |->
		$past(st.lastCode) != st.lastCode)
		else $error("load repeated for unchanged code");
	AST_NO_SCAN_CHAN: assert property (channelSwitchStrobe |-> !$past(scanOn) &&
		!$past(frontLeadsAttached))
		else $error("channel switched during scan or with leads attached");
	AST_KEY_LOCK: assert property (keyLockout == $past(codeOk))
		else $error("key lock does not follow code validity");
endmodule

// *** ecd_ctrl_model.sv ***
// Model of the outside controller that drives the control pins
module ecd_ctrl_model (
	input wire logic clk, // System clock
	output logic channel_selector_enable, // Code means channel when high
	output logic halt, // Scan stop request
	output logic [5:0] code, // Load code
	output logic fire, // Measurement trigger
	output logic low, // Lower digit half select
	output logic spA, // Spare input A
	output logic spB // Spare input B
);
	timeunit 1ns;
	timeprecision 1ps;
	// Shortened stand-in for the long hold; the decoder only needs a few cycles
	localparam int HALT_HOLD = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Idle pin levels
	initial begin
		channel_selector_enable = 1'b0;
		halt = 1'b0;
		code = 6'h00;
		fire = 1'b0;
		low = 1'b0;
		spA = 1'b0;
		spB = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin actions, all changed right after a rising edge
	task set_code(input logic m, input logic [5:0] c);
		@(posedge clk);
		channel_selector_enable <= m;
		code <= c;
		repeat (4) @(posedge clk);
	endtask

	task set_misc(input logic l, input logic a, input logic b);
		@(posedge clk);
		low <= l;
		spA <= a;
		spB <= b;
		repeat (4) @(posedge clk);
	endtask

	// Code held across the whole measurement so the load is not disturbed
	task trigger();
		@(posedge clk);
		fire <= 1'b1;
		repeat (4) @(posedge clk);
		fire <= 1'b0;
		repeat (16) @(posedge clk);
	endtask

	task stop_scan();
		@(posedge clk);
		halt <= 1'b1;
		repeat (HALT_HOLD) @(posedge clk);
		halt <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the control input decoder
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, r;
	logic pready, pslverr, e, channel_selector_enable, halt, fire, low, spA, spB, panelS, chanS, measS;
	logic [5:0] code, loadNumber;
	logic screenReady = 1'b1, leads = 1'b0, measureDone = 1'b0, fault = 1'b0;
	logic fromInit, keyLockout, upper, lower, errorOut, scanStopped, lastInit;
	logic [5:0] lastNum;
	int failures = 0, numChecks = 0, cycles = 0, nPanel, nChan, nMeas, busy = 0;

	ecd_ctrl_model ctl (.clk(clk), .channel_selector_enable(channel_selector_enable), .halt(halt), .code(code), .fire(fire),
		.low(low), .spA(spA), .spB(spB));
	ecd_decoder #(.STABLE_CYCLES(20)) dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .channelSelectorEnable(channel_selector_enable),
		.scanHaltRequest(halt), .loadCodeBit(code), .measureTrigger(fire),
		.bcdLowSelect(low), .spareInputA(spA), .spareInputB(spB), .screenReady(screenReady),
		.frontLeadsAttached(leads), .measureDone(measureDone), .measureFault(fault),
		.panelLoadStrobe(panelS), .channelSwitchStrobe(chanS), .loadNumber(loadNumber),
		.measureStart(measS), .fromInitialChannel(fromInit), .keyLockout(keyLockout),
		.bcdUpperSelect(upper), .bcdLowerSelect(lower), .errorOut(errorOut),
		.scanStopped(scanStopped));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, cycle ceiling, measurement engine stand-in
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end

	// Engine stand-in: done pulse a few cycles after each start, one assignment per edge
	always @(posedge clk) begin
		measureDone <= (measS !== 1'b1) && (busy == 1);
		if (measS === 1'b1) begin
			busy <= 6;
		end else if (busy != 0) begin
			busy <= busy - 1;
		end
	end

	// Pulse tally at mid-cycle, where outputs are settled
	always @(negedge clk) begin
		if (panelS === 1'b1) begin
			nPanel++;
			lastNum = loadNumber;
		end
		if (chanS === 1'b1) begin
			nChan++;
			lastNum = loadNumber;
		end
		if (measS === 1'b1) begin
			nMeas++;
			lastInit = fromInit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Comparison, APB access and reporting
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		numChecks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Request stands until the edge that samples ready high; data taken there
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n == 50) failures++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task clr();
		nPanel = 0;
		nChan = 0;
		nMeas = 0;
	endtask

	// Trigger, then compare panel, channel and measure pulse counts
	task fire_chk(input int p, input int c, input int m, input string what);
		clr();
		ctl.trigger();
		check(nPanel, p, what);
		check(nChan, c, what);
		check(nMeas, m, what);
	endtask

	task summarize();
		$display("checks %0d failures %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b0, 12'h000, 32'h0);
		check(r, 32'h00000008, "ctrl reset");
		apb(1'b0, 12'h008, 32'h0);
		check({r[0], e}, 2'h1, "unmapped");
		// Coded-decimal output on, external trigger kept on
		apb(1'b1, 12'h000, 32'h0000000C);
		ctl.set_misc(1'b0, 1'b1, 1'b0);
		check({upper, lower}, 2'h2, "upper half");
		apb(1'b0, 12'h004, 32'h0);
		check(r & 32'h3, 32'h1, "spare levels");
		ctl.set_misc(1'b1, 1'b0, 1'b1);
		check({upper, lower}, 2'h1, "lower half");
		apb(1'b0, 12'h004, 32'h0);
		check(r & 32'h3, 32'h2, "spare levels b");
		$display("test registers done");
		ctl.set_code(1'b0, 6'h05);
		fire_chk(1, 0, 1, "panel load");
		check(lastNum, 6'h05, "panel number");
		fire_chk(0, 0, 1, "same code");
		ctl.set_code(1'b1, 6'h20);
		fire_chk(0, 1, 1, "channel load");
		check(lastNum, 6'h20, "channel number");
		clr();
		ctl.set_code(1'b0, 6'h07);
		repeat (40) @(posedge clk);
		check({nPanel[1:0], nMeas[1:0]}, 4'h4, "auto load");
		check(keyLockout, 1'b1, "keys locked");
		ctl.set_code(1'b0, 6'h00);
		check(keyLockout, 1'b0, "keys free");
		$display("test loads done");
		screenReady <= 1'b0;
		ctl.set_code(1'b0, 6'h09);
		fire_chk(0, 0, 0, "screen hidden");
		ctl.set_code(1'b0, 6'h00);
		screenReady <= 1'b1;
		leads <= 1'b1;
		ctl.set_code(1'b1, 6'h04);
		fire_chk(0, 0, 0, "leads refuse");
		check(errorOut, 1'b1, "leads error");
		leads <= 1'b0;
		fire_chk(0, 1, 1, "leads off");
		check(errorOut, 1'b0, "error cleared");
		fault <= 1'b1;
		fire_chk(0, 0, 1, "faulty measure");
		check(errorOut, 1'b1, "fault error");
		fault <= 1'b0;
		$display("test errors done");
		apb(1'b1, 12'h000, 32'h00000009);
		ctl.set_code(1'b1, 6'h0A);
		fire_chk(0, 0, 1, "scan keeps channel");
		ctl.stop_scan();
		fire_chk(0, 0, 1, "auto halt measure");
		check(scanStopped, 1'b1, "scan stopped");
		fire_chk(0, 0, 1, "auto restart");
		check(lastInit, 1'b1, "auto from first");
		apb(1'b1, 12'h000, 32'h0000000A);
		ctl.stop_scan();
		fire_chk(0, 0, 1, "step restart");
		check(lastInit, 1'b1, "step from first");
		apb(1'b1, 12'h000, 32'h00000008);
		ctl.stop_scan();
		// Scan off: new channel code is applied on the trigger again
		fire_chk(0, 1, 1, "scan off");
		check(lastInit, 1'b0, "halt ignored");
		$display("test scan done");
		summarize();
	end
endmodule
